/* File: rtl/mms_consts.vh */
// Constants for the serial master command scheduler: register map, field
// widths, reset values, function and option codes, and timing figures.
// Assumes it is included once per design file by its bare name.
`ifndef MMS_CONSTS_VH
`define MMS_CONSTS_VH

// ==========================================================================
// Register port addresses (word index on the plain register port)
`define MMS_A_CTRL 8'h00
`define MMS_A_CMD_COUNT 8'h01
`define MMS_A_CMD_DELAY 8'h02
`define MMS_A_TIMEOUT 8'h03
`define MMS_A_RETRY 8'h04
`define MMS_A_REC_SEL 8'h05
`define MMS_A_TRIGGER 8'h06
`define MMS_A_STATUS 8'h07
`define MMS_A_ERR_COUNT 8'h08
`define MMS_A_R_ENABLE 8'h10
`define MMS_A_R_INT_ADDR 8'h11
`define MMS_A_R_POLL 8'h12
`define MMS_A_R_COUNT 8'h13
`define MMS_A_R_SWAP 8'h14
`define MMS_A_R_NODE 8'h15
`define MMS_A_R_FUNC 8'h16
`define MMS_A_R_DEV_ADDR 8'h17
`define MMS_A_R_END 8'h18

// ==========================================================================
// Sizes and limits
`define MMS_NREC 100
`define MMS_IDX_W 7
`define MMS_MAX_CMDS 7'h64
`define MMS_MAX_RETRY 4'ha
`define MMS_ZERO16 16'h0000
`define MMS_ONE16 16'h0001
`define MMS_SAT16 16'hffff

// ==========================================================================
// Enable codes, swap codes and function codes
`define MMS_EN_OFF 2'h0
`define MMS_EN_POLL 2'h1
`define MMS_EN_CHANGE 2'h2
`define MMS_SW_NONE 2'h0
`define MMS_SW_WORDS 2'h1
`define MMS_SW_BOTH 2'h2
`define MMS_SW_BYTES 2'h3
`define MMS_FC_RD_COILS 8'h01
`define MMS_FC_RD_INPUTS 8'h02
`define MMS_FC_RD_HOLD 8'h03
`define MMS_FC_RD_INREG 8'h04
`define MMS_FC_WR_COIL 8'h05
`define MMS_FC_WR_REG 8'h06
`define MMS_FC_WR_COILS 8'h0f
`define MMS_FC_WR_REGS 8'h10
`define MMS_NODE_BCAST 8'h00

// ==========================================================================
// Timing: clock period, millisecond length and seconds timebase
`define MMS_CLK_NS 100
`define MMS_MS_NS 1000000
`define MMS_MS_PER_SEC 10'd1000

`endif

/* File: rtl/mms_tick.v */
// Millisecond and second timebase for the command scheduler.
// Assumes a free-running clock; the cycle count per millisecond is a parameter.
`include "mms_consts.vh"

module mms_tick #(
  parameter MS_CYCLES = 10000
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Tick outputs
  output reg ms_tick_ff,
  output reg sec_tick_ff
);

  reg [23:0] cyc_ff;
  reg [9:0] ms_ff;
  wire cyc_end;
  wire ms_end;

  assign cyc_end = (cyc_ff == MS_CYCLES[23:0] - 24'h000001);
  assign ms_end = (ms_ff == `MMS_MS_PER_SEC - 10'd1);

  // ==========================================================================
  // Divider chain; the ticks are single-cycle pulses taken from flip-flops.
  always @(posedge clk) begin
    if (!rst_n) begin
      cyc_ff <= 24'h000000;
      ms_ff <= 10'd0;
      ms_tick_ff <= 1'b0;
      sec_tick_ff <= 1'b0;
    end else begin
      cyc_ff <= cyc_end ? 24'h000000 : cyc_ff + 24'h000001;
      ms_tick_ff <= cyc_end;
      sec_tick_ff <= cyc_end && ms_end;
      if (cyc_end) begin
        ms_ff <= ms_end ? 10'd0 : ms_ff + 10'd1;
      end
    end
  end

endmodule

/* File: rtl/mms_swap.v */
// Reorders a received register pair before it is stored in the database.
// Assumes the first received register sits in bits 31:16 of the input.
`include "mms_consts.vh"

module mms_swap (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Incoming pair
  input wire in_valid,
  input wire [31:0] in_data,
  input wire [1:0] swap,
  // Reordered pair
  output reg out_valid_ff,
  output reg [31:0] out_data_ff
);

  reg [31:0] nxt_data;

  // ==========================================================================
  // Words swap exchanges the halves; bytes swap acts inside each half.
  always @* begin
    case (swap)
      `MMS_SW_WORDS: nxt_data = {in_data[15:0], in_data[31:16]};
      `MMS_SW_BOTH: nxt_data = {in_data[7:0], in_data[15:8], in_data[23:16], in_data[31:24]};
      `MMS_SW_BYTES: nxt_data = {in_data[23:16], in_data[31:24], in_data[7:0], in_data[15:8]};
      default: nxt_data = in_data;
    endcase
  end

  // Registered so the database write data comes from flip-flops.
  always @(posedge clk) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= 32'h00000000;
    end else begin
      out_valid_ff <= in_valid;
      out_data_ff <= nxt_data;
    end
  end

endmodule

/* File: rtl/mms_sched.v */
// Serial master command scheduler: record table, polling walk, retries.
// Assumes a serial framer takes requests, returns register pairs and a done
// pulse, and that the database reports writes to it on chg_valid.
`include "mms_consts.vh"

// Function
// - Walk records from index 0; stop at end mark or command count.
// - Enable 0 skips normal polling; trigger register still runs it.
// - Enable 1 with zero interval runs every pass.
// - Enable 1 with interval runs only after its seconds timer expires.
// - Enable 2 runs only after its database data changed; writes only.
// - Database start address drives read storage and write sourcing.
// - Functions 5 and 6 send a count of exactly one.
// - Count means points for 1, 2, 15; registers for 3, 4, 16.
// - Received pairs reordered per swap code 0 to 3.
// - Node 1 to 255 is placed in the request address field.
// - Node 0 broadcasts; reads to node 0 are refused.
// - Only function codes 1-6, 15 and 16 are issued.
// - Slave start address is sent as the first point or register.
// - No answer within the millisecond timeout retransmits.
// - Failed command retried up to the retry count, zero to ten.
// - Command delay waited before new commands, not before retries.
// - Command count is configurable from zero to one hundred.
module mms_sched #(
  parameter MS_CYCLES = `MMS_MS_NS / `MMS_CLK_NS
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_ff,
  // Request to the serial framer
  output wire req_valid,
  input wire req_ready,
  output reg [7:0] req_node_ff,
  output reg [7:0] req_func_ff,
  output reg [15:0] req_dev_addr_ff,
  output reg [15:0] req_count_ff,
  output reg req_bits_ff,
  output reg [11:0] req_db_addr_ff,
  // Answer from the serial framer
  input wire rx_valid,
  input wire [31:0] rx_data,
  input wire resp_done,
  input wire resp_ok,
  // Database write port for received data
  output wire db_wr_valid,
  output wire [31:0] db_wr_data,
  output reg [11:0] db_wr_addr_ff,
  // Database change report
  input wire chg_valid,
  input wire [11:0] chg_addr
);

  localparam S_SCAN = 6'h01;
  localparam S_DELAY = 6'h02;
  localparam S_ISSUE = 6'h04;
  localparam S_WAIT = 6'h08;
  localparam S_DONE = 6'h10;
  localparam S_IDLE = 6'h20;

  // Record table.
  reg [1:0] rec_en_ff [0:`MMS_NREC-1];
  reg [11:0] rec_int_ff [0:`MMS_NREC-1];
  reg [15:0] rec_poll_ff [0:`MMS_NREC-1];
  reg [15:0] rec_cnt_ff [0:`MMS_NREC-1];
  reg [1:0] rec_swap_ff [0:`MMS_NREC-1];
  reg [7:0] rec_node_ff [0:`MMS_NREC-1];
  reg [7:0] rec_func_ff [0:`MMS_NREC-1];
  reg [15:0] rec_dev_ff [0:`MMS_NREC-1];
  reg rec_end_ff [0:`MMS_NREC-1];
  // Global configuration and status.
  reg run_ff;
  reg [6:0] cmd_count_ff;
  reg [15:0] cmd_delay_ff;
  reg [15:0] timeout_ff;
  reg [3:0] retry_cfg_ff;
  reg [6:0] rec_sel_ff;
  reg [15:0] err_count_ff;
  reg [`MMS_NREC-1:0] trig_ff;
  reg [`MMS_NREC-1:0] chg_ff;
  wire [`MMS_NREC-1:0] expired;
  // Walk state.
  reg [5:0] state_ff;
  reg [6:0] scan_idx_ff;
  reg [6:0] cur_idx_ff;
  reg cur_trig_ff;
  reg [15:0] tmr_ff;
  reg [3:0] retries_ff;
  reg last_fail_ff;
  reg trig_any;
  reg [6:0] trig_idx;
  reg [6:0] sel_idx;
  reg sel_go;
  reg sel_valid;
  reg [15:0] sel_count;
  reg sel_bits;
  wire issued;
  wire ms_tick;
  wire sec_tick;
  wire swap_valid;
  integer k, j;

  assign req_valid = (state_ff == S_ISSUE);
  assign issued = (state_ff == S_DONE);

  mms_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .ms_tick_ff(ms_tick),
    .sec_tick_ff(sec_tick)
  );

  mms_swap u_swap (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rx_valid && state_ff == S_WAIT),
    .in_data(rx_data),
    .swap(rec_swap_ff[cur_idx_ff]),
    .out_valid_ff(swap_valid),
    .out_data_ff(db_wr_data)
  );
  assign db_wr_valid = swap_valid;

  // ==========================================================================
  // Per-record timers and change flags. A new event beats the clear that
  // comes with issuing, so a change landing in that cycle runs again.
  genvar g;
  generate
    for (g = 0; g < `MMS_NREC; g = g + 1) begin : g_rec
      reg [15:0] secs_ff;
      wire [15:0] span;
      wire in_range;
      assign span = (rec_func_ff[g] == `MMS_FC_WR_COIL || rec_func_ff[g] == `MMS_FC_WR_REG) ?
                    `MMS_ONE16 : (rec_func_ff[g] == `MMS_FC_WR_COILS) ?
                    ((rec_cnt_ff[g] + 16'h000f) >> 4) : rec_cnt_ff[g];
      assign in_range = ({4'h0, chg_addr} >= {4'h0, rec_int_ff[g]}) &&
                        ({4'h0, chg_addr} < {4'h0, rec_int_ff[g]} + span);
      assign expired[g] = (secs_ff >= rec_poll_ff[g]);
      always @(posedge clk) begin
        if (!rst_n) begin
          secs_ff <= `MMS_ZERO16;
        end else if (issued && cur_idx_ff == g) begin
          secs_ff <= `MMS_ZERO16;
        end else if (sec_tick && secs_ff != `MMS_SAT16) begin
          secs_ff <= secs_ff + `MMS_ONE16;
        end
      end
      always @(posedge clk) begin
        if (!rst_n) begin
          chg_ff[g] <= 1'b0;
        end else if (chg_valid && in_range) begin
          chg_ff[g] <= 1'b1;
        end else if (issued && cur_idx_ff == g) begin
          chg_ff[g] <= 1'b0;
        end
      end
      always @(posedge clk) begin
        if (!rst_n) begin
          trig_ff[g] <= 1'b0;
        end else if (reg_wr && reg_addr == `MMS_A_TRIGGER && reg_wdata[6:0] == g) begin
          trig_ff[g] <= 1'b1;
        end else if (issued && cur_trig_ff && cur_idx_ff == g) begin
          trig_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Selection: triggers first (lowest index), else the record at scan index.
  always @* begin
    trig_any = 1'b0;
    trig_idx = 7'h00;
    for (k = `MMS_NREC - 1; k >= 0; k = k - 1) begin
      if (trig_ff[k]) begin
        trig_any = 1'b1;
        trig_idx = k[6:0];
      end
    end
    sel_idx = trig_any ? trig_idx : scan_idx_ff;
    case (rec_func_ff[sel_idx])
      `MMS_FC_RD_COILS, `MMS_FC_RD_INPUTS, `MMS_FC_RD_HOLD, `MMS_FC_RD_INREG: begin
        sel_valid = (rec_node_ff[sel_idx] != `MMS_NODE_BCAST); // no broadcast read
        sel_go = (rec_en_ff[sel_idx] == `MMS_EN_POLL) &&
                 (rec_poll_ff[sel_idx] == `MMS_ZERO16 || expired[sel_idx]);
      end
      `MMS_FC_WR_COIL, `MMS_FC_WR_REG, `MMS_FC_WR_COILS, `MMS_FC_WR_REGS: begin
        sel_valid = 1'b1;
        sel_go = ((rec_en_ff[sel_idx] == `MMS_EN_POLL) &&
                  (rec_poll_ff[sel_idx] == `MMS_ZERO16 || expired[sel_idx])) ||
                 ((rec_en_ff[sel_idx] == `MMS_EN_CHANGE) && chg_ff[sel_idx]);
      end
      default: begin
        sel_valid = 1'b0;
        sel_go = 1'b0;
      end
    endcase
    if (trig_any) begin
      sel_go = 1'b1;
    end
    case (rec_func_ff[sel_idx])
      `MMS_FC_WR_COIL, `MMS_FC_WR_REG: sel_count = `MMS_ONE16;
      default: sel_count = rec_cnt_ff[sel_idx];
    endcase
    sel_bits = (rec_func_ff[sel_idx] == `MMS_FC_RD_COILS) ||
               (rec_func_ff[sel_idx] == `MMS_FC_RD_INPUTS) ||
               (rec_func_ff[sel_idx] == `MMS_FC_WR_COIL) ||
               (rec_func_ff[sel_idx] == `MMS_FC_WR_COILS);
  end

  // ==========================================================================
  // Command walk. The delay is taken once per new command; retries go
  // straight back to the issue state.
  always @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      scan_idx_ff <= 7'h00;
      cur_idx_ff <= 7'h00;
      cur_trig_ff <= 1'b0;
      tmr_ff <= `MMS_ZERO16;
      retries_ff <= 4'h0;
      last_fail_ff <= 1'b0;
      err_count_ff <= `MMS_ZERO16;
      req_node_ff <= 8'h00;
      req_func_ff <= 8'h00;
      req_dev_addr_ff <= `MMS_ZERO16;
      req_count_ff <= `MMS_ZERO16;
      req_bits_ff <= 1'b0;
      req_db_addr_ff <= 12'h000;
      db_wr_addr_ff <= 12'h000;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (run_ff || trig_any) begin
            state_ff <= S_SCAN;
          end
        end
        S_SCAN: begin
          if (!trig_any && (!run_ff || scan_idx_ff >= cmd_count_ff ||
              rec_end_ff[scan_idx_ff])) begin
            scan_idx_ff <= 7'h00;
            state_ff <= S_IDLE;
          end else if (sel_go && sel_valid) begin
            cur_idx_ff <= sel_idx;
            cur_trig_ff <= trig_any;
            req_node_ff <= rec_node_ff[sel_idx]; // node field
            req_func_ff <= rec_func_ff[sel_idx];
            req_dev_addr_ff <= rec_dev_ff[sel_idx]; // slave start
            req_count_ff <= sel_count;
            req_bits_ff <= sel_bits;
            req_db_addr_ff <= rec_int_ff[sel_idx];
            db_wr_addr_ff <= rec_int_ff[sel_idx];
            retries_ff <= 4'h0;
            tmr_ff <= `MMS_ZERO16;
            state_ff <= S_DELAY;
          end else begin
            if (trig_any) begin
              cur_idx_ff <= sel_idx;
              cur_trig_ff <= 1'b1;
              err_count_ff <= err_count_ff + `MMS_ONE16;
              state_ff <= S_DONE;
            end else begin
              scan_idx_ff <= scan_idx_ff + 7'h01;
            end
          end
        end
        S_DELAY: begin
          if (tmr_ff >= cmd_delay_ff) begin
            state_ff <= S_ISSUE;
          end else if (ms_tick) begin
            tmr_ff <= tmr_ff + `MMS_ONE16;
          end
        end
        S_ISSUE: begin
          if (req_ready) begin
            tmr_ff <= `MMS_ZERO16;
            state_ff <= (req_node_ff == `MMS_NODE_BCAST) ? S_DONE : S_WAIT;
            last_fail_ff <= 1'b0;
          end
        end
        S_WAIT: begin
          if (swap_valid) begin
            db_wr_addr_ff <= db_wr_addr_ff + 12'h002;
          end
          if ((resp_done && !resp_ok) || (!resp_done && tmr_ff >= timeout_ff)) begin
            if (retries_ff < retry_cfg_ff) begin
              retries_ff <= retries_ff + 4'h1;
              db_wr_addr_ff <= req_db_addr_ff;
              state_ff <= S_ISSUE;
            end else begin
              last_fail_ff <= 1'b1;
              err_count_ff <= err_count_ff + `MMS_ONE16;
              state_ff <= S_DONE;
            end
          end else if (resp_done) begin
            state_ff <= S_DONE;
          end else if (ms_tick) begin
            tmr_ff <= tmr_ff + `MMS_ONE16;
          end
        end
        S_DONE: begin
          if (!cur_trig_ff) begin
            scan_idx_ff <= cur_idx_ff + 7'h01;
          end
          state_ff <= S_SCAN;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Register writes. Command count and retry values above their range are clamped; a record select whose low seven bits exceed 99 falls to 0.
  always @(posedge clk) begin
    if (!rst_n) begin
      run_ff <= 1'b0;
      cmd_count_ff <= 7'h00;
      cmd_delay_ff <= `MMS_ZERO16;
      timeout_ff <= `MMS_ZERO16;
      retry_cfg_ff <= 4'h0;
      rec_sel_ff <= 7'h00;
      for (j = 0; j < `MMS_NREC; j = j + 1) begin
        rec_en_ff[j] <= `MMS_EN_OFF;
        rec_int_ff[j] <= 12'h000;
        rec_poll_ff[j] <= `MMS_ZERO16;
        rec_cnt_ff[j] <= `MMS_ZERO16;
        rec_swap_ff[j] <= `MMS_SW_NONE;
        rec_node_ff[j] <= 8'h00;
        rec_func_ff[j] <= 8'h00;
        rec_dev_ff[j] <= `MMS_ZERO16;
        rec_end_ff[j] <= 1'b0;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `MMS_A_CTRL: run_ff <= reg_wdata[0];
        `MMS_A_CMD_COUNT: cmd_count_ff <= (reg_wdata > {9'h000, `MMS_MAX_CMDS}) ?
                                          `MMS_MAX_CMDS : reg_wdata[6:0];
        `MMS_A_CMD_DELAY: cmd_delay_ff <= reg_wdata;
        `MMS_A_TIMEOUT: timeout_ff <= reg_wdata;
        `MMS_A_RETRY: retry_cfg_ff <= (reg_wdata > {12'h000, `MMS_MAX_RETRY}) ?
                                      `MMS_MAX_RETRY : reg_wdata[3:0];
        `MMS_A_REC_SEL: rec_sel_ff <= (reg_wdata[6:0] < `MMS_MAX_CMDS) ? reg_wdata[6:0] : 7'h00;
        `MMS_A_R_ENABLE: rec_en_ff[rec_sel_ff] <= reg_wdata[1:0];
        `MMS_A_R_INT_ADDR: rec_int_ff[rec_sel_ff] <= reg_wdata[11:0];
        `MMS_A_R_POLL: rec_poll_ff[rec_sel_ff] <= reg_wdata;
        `MMS_A_R_COUNT: rec_cnt_ff[rec_sel_ff] <= reg_wdata;
        `MMS_A_R_SWAP: rec_swap_ff[rec_sel_ff] <= reg_wdata[1:0];
        `MMS_A_R_NODE: rec_node_ff[rec_sel_ff] <= reg_wdata[7:0];
        `MMS_A_R_FUNC: rec_func_ff[rec_sel_ff] <= reg_wdata[7:0];
        `MMS_A_R_DEV_ADDR: rec_dev_ff[rec_sel_ff] <= reg_wdata;
        `MMS_A_R_END: rec_end_ff[rec_sel_ff] <= reg_wdata[0];
        default: run_ff <= run_ff;
      endcase
    end
  end

  // ==========================================================================
  // Register reads: data stands in the cycle after the strobe only.
  always @(posedge clk) begin
    if (!rst_n || !reg_rd) begin
      reg_rdata_ff <= `MMS_ZERO16;
    end else begin
      case (reg_addr)
        `MMS_A_CTRL: reg_rdata_ff <= {15'h0000, run_ff};
        `MMS_A_CMD_COUNT: reg_rdata_ff <= {9'h000, cmd_count_ff};
        `MMS_A_CMD_DELAY: reg_rdata_ff <= cmd_delay_ff;
        `MMS_A_TIMEOUT: reg_rdata_ff <= timeout_ff;
        `MMS_A_RETRY: reg_rdata_ff <= {12'h000, retry_cfg_ff};
        `MMS_A_REC_SEL: reg_rdata_ff <= {9'h000, rec_sel_ff};
        `MMS_A_STATUS: reg_rdata_ff <= {last_fail_ff, (state_ff != S_IDLE), retries_ff,
                                        3'h0, cur_idx_ff};
        `MMS_A_ERR_COUNT: reg_rdata_ff <= err_count_ff;
        `MMS_A_R_ENABLE: reg_rdata_ff <= {14'h0000, rec_en_ff[rec_sel_ff]};
        `MMS_A_R_INT_ADDR: reg_rdata_ff <= {4'h0, rec_int_ff[rec_sel_ff]};
        `MMS_A_R_POLL: reg_rdata_ff <= rec_poll_ff[rec_sel_ff];
        `MMS_A_R_COUNT: reg_rdata_ff <= rec_cnt_ff[rec_sel_ff];
        `MMS_A_R_SWAP: reg_rdata_ff <= {14'h0000, rec_swap_ff[rec_sel_ff]};
        `MMS_A_R_NODE: reg_rdata_ff <= {8'h00, rec_node_ff[rec_sel_ff]};
        `MMS_A_R_FUNC: reg_rdata_ff <= {8'h00, rec_func_ff[rec_sel_ff]};
        `MMS_A_R_DEV_ADDR: reg_rdata_ff <= rec_dev_ff[rec_sel_ff];
        `MMS_A_R_END: reg_rdata_ff <= {15'h0000, rec_end_ff[rec_sel_ff]};
        default: reg_rdata_ff <= `MMS_ZERO16;
      endcase
    end
  end

endmodule

/* File: sim/mms_sched_assertions.sv */
// Port checker for the command scheduler, bound to every mms_sched instance.
// Assumes one clock domain with a synchronous active-low reset.
// ==========================================
// Checker
module mms_sched_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port and request side
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_ff,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_node_ff,
  input wire logic [7:0] req_func_ff,
  input wire logic [15:0] req_dev_addr_ff,
  input wire logic [15:0] req_count_ff,
  input wire logic req_bits_ff,
  // Answer and store
  input wire logic rx_valid,
  input wire logic db_wr_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Request fields are judged only while a request is offered.
  chk_single_point: assert property (req_valid && (req_func_ff == 8'h05 ||
    req_func_ff == 8'h06) |-> req_count_ff == 16'h0001) else $error("single write count");
  chk_func_known: assert property (req_valid |-> req_func_ff inside
    {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10}) else $error("bad function");
  chk_no_bcast_read: assert property (req_valid && req_node_ff == 8'h00 |->
    req_func_ff inside {8'h05, 8'h06, 8'h0f, 8'h10}) else $error("broadcast read");
  chk_count_kind: assert property (req_valid |->
    req_bits_ff == (req_func_ff inside {8'h01, 8'h02, 8'h05, 8'h0f})) else $error("count kind");
  chk_req_held: assert property (req_valid && !req_ready |=> req_valid &&
    $stable(req_dev_addr_ff) && $stable(req_node_ff)) else $error("request dropped");
  chk_store_follow: assert property (rx_valid |=> db_wr_valid) else $error("pair not stored");
  chk_store_cause: assert property (db_wr_valid |-> $past(rx_valid)) else $error("stray store");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata_ff == 16'h0000)
    else $error("read data outside slot");
  // Main scenarios.
  cov_bcast: cover property (req_valid && req_ready && req_node_ff == 8'h00);
  cov_read: cover property (req_valid && req_ready && req_func_ff == 8'h03);
  cov_store: cover property (db_wr_valid);
endmodule

bind mms_sched mms_sched_assertions mms_sched_assertions_i (.clk(clk), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .req_valid(req_valid), .req_ready(req_ready),
  .req_node_ff(req_node_ff), .req_func_ff(req_func_ff), .req_dev_addr_ff(req_dev_addr_ff),
  .req_count_ff(req_count_ff), .req_bits_ff(req_bits_ff), .rx_valid(rx_valid),
  .db_wr_valid(db_wr_valid));

/* File: sim/mms_slave_model.sv */
// Framer and slave stand-in: takes requests, answers reads with one pair.
// Assumes the bench sets the lag and may silence it to force timeouts.
// ==========================================
// Slave model
module mms_slave_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request side
  input wire logic req_valid,
  input wire logic [7:0] req_node_ff,
  input wire logic [7:0] req_func_ff,
  output logic req_ready,
  // Answer side
  output logic rx_valid,
  output logic [31:0] rx_data,
  output logic resp_done,
  output logic resp_ok,
  // Bench controls
  input wire logic silent,
  input wire logic [3:0] lag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic busy;
  // Strobes are pulses; data not in use toggles so stale values never match.
  always @(posedge clk) begin
    req_ready <= 1'b0;
    rx_valid <= 1'b0;
    resp_done <= 1'b0;
    resp_ok <= 1'b0;
    rx_data <= ~rx_data;
    if (!rst_n) begin
      cnt <= 4'h0;
      busy <= 1'b0;
      rx_data <= 32'h0;
    end else if (busy) begin
      cnt <= cnt + 4'h1;
      if (cnt == lag) begin
        rx_valid <= 1'b1;
        rx_data <= 32'h11223344;
      end
      if (cnt == lag + 4'h1) begin
        resp_done <= 1'b1;
        resp_ok <= 1'b1;
        busy <= 1'b0;
      end
    end else if (req_valid && !req_ready) begin
      if (cnt == lag) begin
        req_ready <= 1'b1;
        cnt <= 4'h0;
        busy <= !silent && req_node_ff != 8'h00 && req_func_ff <= 8'h04;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

/* File: sim/tb_mms_sched.sv */
// Bench for the command scheduler: register tasks, request monitor, verdict.
// Assumes the slave model answers and MS_CYCLES is cut to 10 cycles.
`include "mms_consts.vh"
// ==========================================
// Bench
module tb_mms_sched;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, silent = 0, chg_valid = 0;
  logic [7:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic [3:0] lag = 0;
  logic [11:0] chg_addr = 12'h040;
  wire req_valid, req_ready, rx_valid, resp_done, resp_ok, db_wr_valid, req_bits_ff;
  wire [15:0] reg_rdata_ff, req_dev_addr_ff, req_count_ff;
  wire [7:0] req_node_ff, req_func_ff;
  wire [11:0] req_db_addr_ff, db_wr_addr_ff;
  wire [31:0] rx_data, db_wr_data;
  int n_fail = 0, cmp_count = 0, n_take = 0, cyc = 0, n;
  logic [47:0] t_req;
  logic [31:0] d_data;
  mms_sched #(.MS_CYCLES(10)) mms_sched_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .req_valid(req_valid), .req_ready(req_ready), .req_node_ff(req_node_ff),
    .req_func_ff(req_func_ff), .req_dev_addr_ff(req_dev_addr_ff), .req_count_ff(req_count_ff),
    .req_bits_ff(req_bits_ff), .req_db_addr_ff(req_db_addr_ff), .rx_valid(rx_valid),
    .rx_data(rx_data), .resp_done(resp_done), .resp_ok(resp_ok), .db_wr_valid(db_wr_valid),
    .db_wr_data(db_wr_data), .db_wr_addr_ff(db_wr_addr_ff), .chg_valid(chg_valid),
    .chg_addr(chg_addr));
  mms_slave_model mms_slave_model_i (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_node_ff(req_node_ff), .req_func_ff(req_func_ff), .req_ready(req_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .resp_done(resp_done), .resp_ok(resp_ok),
    .silent(silent), .lag(lag));
  initial forever #50 clk = ~clk;
  // Monitor takes and stores; a hang past the ceiling ends the run as failed.
  always @(posedge clk) begin
    cyc++;
    if (req_valid && req_ready) begin
      n_take++;
      t_req <= {req_node_ff, req_func_ff, req_dev_addr_ff, req_count_ff};
    end
    if (db_wr_valid) d_data <= db_wr_data;
    if (cyc == 20000) begin
      chk(cyc, 0);
      end_of_test();
    end
  end
  task chk(input logic [47:0] g, input logic [47:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is looked at in the one cycle where it stands.
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_ff, e);
  endtask
  task wait_take(input int m);
    int k;
    k = 0;
    while (n_take < m && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
    if (k > 2999) chk(k, 0);
    repeat (12) @(posedge clk);
  endtask
  task rec(input logic [6:0] i, input logic [1:0] en, input logic [7:0] fc, input logic [7:0] nd,
      input logic [15:0] cnt, input logic last);
    wr(`MMS_A_REC_SEL, {9'h0, i});
    wr(`MMS_A_R_ENABLE, {14'h0, en});
    wr(`MMS_A_R_INT_ADDR, 16'h0040);
    wr(`MMS_A_R_COUNT, cnt);
    wr(`MMS_A_R_NODE, {8'h0, nd});
    wr(`MMS_A_R_FUNC, {8'h0, fc});
    wr(`MMS_A_R_DEV_ADDR, 16'h1230 + i);
    wr(`MMS_A_R_END, {15'h0, last});
  endtask
  function automatic logic [31:0] swp(input logic [31:0] d, input int s);
    case (s)
      0: return d;
      1: return {d[15:0], d[31:16]};
      2: return {d[7:0], d[15:8], d[23:16], d[31:24]};
      default: return {d[23:16], d[31:24], d[7:0], d[15:8]};
    endcase
  endfunction
  task end_of_test();
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence: limits, one polling pass with wrap, triggers, timeouts.
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(`MMS_A_STATUS, 16'h0000);
    wr(`MMS_A_CMD_COUNT, 16'h00c8);
    rd(`MMS_A_CMD_COUNT, 16'h0064);
    wr(`MMS_A_RETRY, 16'h000f);
    rd(`MMS_A_RETRY, 16'h000a);
    rd(8'h20, 16'h0000);
    wr(`MMS_A_CMD_COUNT, 16'h0003);
    wr(`MMS_A_CMD_DELAY, 16'h0002);
    wr(`MMS_A_TIMEOUT, 16'h0005);
    wr(`MMS_A_RETRY, 16'h0001);
    rec(0, `MMS_EN_POLL, `MMS_FC_RD_HOLD, 8'h05, 16'h0002, 1'b0);
    rec(1, `MMS_EN_POLL, `MMS_FC_WR_REG, `MMS_NODE_BCAST, 16'h0007, 1'b0);
    rec(2, `MMS_EN_POLL, `MMS_FC_RD_COILS, 8'h09, 16'h0004, 1'b1);
    wr(`MMS_A_CTRL, 16'h0001);
    wait_take(1);
    chk(t_req, 48'h0503_1230_0002);
    chk(d_data, 32'h11223344);
    wait_take(2);
    chk(t_req, 48'h0006_1231_0001);
    wait_take(3);
    chk(t_req, 48'h0503_1230_0002);
    rec(1, `MMS_EN_CHANGE, `MMS_FC_WR_REG, `MMS_NODE_BCAST, 16'h0007, 1'b0);
    rec(0, `MMS_EN_OFF, `MMS_FC_RD_HOLD, 8'h05, 16'h0002, 1'b0);
    repeat (100) @(posedge clk);
    lag <= 4'h3;
    for (int s = 0; s < 4; s++) begin
      wr(`MMS_A_R_SWAP, s[15:0]);
      n = n_take;
      wr(`MMS_A_TRIGGER, 16'h0000);
      wait_take(n + 1);
      chk(d_data, swp(32'h11223344, s));
    end
    chk(n_take, n + 1);
    silent <= 1'b1;
    wr(`MMS_A_TRIGGER, 16'h0000);
    wait_take(n + 3);
    repeat (80) @(posedge clk);
    rd(`MMS_A_ERR_COUNT, 16'h0001);
    chk(n_take, n + 3);
    @(posedge clk) chg_valid <= 1'b1;
    @(posedge clk) chg_valid <= 1'b0;
    wait_take(n + 4);
    chk(t_req, 48'h0006_1231_0001);
    end_of_test();
  end
endmodule
